//--- include/lps_consts.vh
`ifndef LPS_CONSTS_VH
`define LPS_CONSTS_VH
// register offsets (word index on the plain port)
`define LPS_A_CTRL      4'h0
`define LPS_A_WAKE_EN   4'h1
`define LPS_A_RET_MASK  4'h2
`define LPS_A_TMR_LO    4'h3
`define LPS_A_TMR_HI    4'h4
`define LPS_A_SW_RST    4'h5
`define LPS_A_STATUS    4'h6
`define LPS_A_CAUSE     4'h7
`define LPS_A_BROWN     4'h8
// ctrl command field bits [2:0]
`define LPS_CMD_NONE    3'h0
`define LPS_CMD_RET     3'h1
`define LPS_CMD_HIB     3'h2
`define LPS_CMD_OFF     3'h3
`define LPS_CTRL_IDLE   3
`define LPS_CTRL_RSLP   4
// wake enable bit positions
`define LPS_W_TMR       0
`define LPS_W_GPIO      1
`define LPS_W_KBD       2
`define LPS_W_MOUSE     3
`define LPS_W_HUB       4
`define LPS_W_DBG       5
`define LPS_W_PIN       6
`define LPS_W_CMP       7
// reset values
`define LPS_RET_RST     8'hff
// supply settle time before reset release
`define LPS_SETTLE_US   10
`define LPS_CLK_MHZ     50
`define LPS_SETTLE_CYC  (`LPS_SETTLE_US * `LPS_CLK_MHZ)
// low power tick: 50 MHz / 32768 is about 1526
`define LPS_LP_DIV      11'd1526
`endif

//--- rtl/lps_sequencer.v
// Contract
// - five primary states with idle and radio sleep substates
// - chip reset held until supplies report stable
// - power-down pin acts as the external reset
// - software register write resets individual modules
// - active powers all regions; cpu idle and clock gating allowed
// - radio sleep powers down radio only
// - retention keeps selected 16 kB sram slices of eight
// - retention keeps all flip-flop state
// - outputs hold level sampled at start of retention or hibernation
// - retention wakes on any enabled source among six
// - hibernation powers down memory, keeps minimal state, holds pins
// - soc-off unpowers all digital domains, power unit stays on
// - leaving soc-off always does a full cold reset
// - soc-off wakes only by 40-bit timer, wake pin or comparator
// - power-down pin turns every domain and supply off
// - sensor hub threshold can wake the chip
// - several brownout interrupts toward the processor
// - soc-off timer is 40-bit counter on the 32 kHz tick
`timescale 1ns/1ns
`include "lps_consts.vh"
module lps_sequencer (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        power_down_pin_i,
   input  wire        supply_ok_i,
   input  wire [2:0]  brownout_i,
   input  wire        wake_gpio_i,
   input  wire        wake_kbd_i,
   input  wire        wake_mouse_i,
   input  wire        wake_hub_i,
   input  wire        wake_dbg_i,
   input  wire        soc_off_wake_input_i,
   input  wire        comparator_wake_input_i,
   input  wire        cpu_wfi_i,
   input  wire [11:0] io_level_i,
   input  wire [3:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rdata_o,
   output reg         chip_rst_n_o,
   output reg  [7:0]  mod_rst_o,
   output reg         pwr_core_o,
   output reg         pwr_top_o,
   output reg         pwr_radio_o,
   output reg         pwr_pmu_o,
   output reg  [7:0]  sram_pwr_o,
   output reg         cpu_clk_en_o,
   output reg         io_hold_o,
   output reg  [11:0] io_level_o,
   output reg  [2:0]  brownout_irq_o,
   output reg  [2:0]  pstate_o
);
   localparam ST_RESET = 3'h0;
   localparam ST_ACT   = 3'h1;
   localparam ST_RET   = 3'h2;
   localparam ST_HIB   = 3'h3;
   localparam ST_OFF   = 3'h4;
   localparam ST_PWD   = 3'h5;

   // three-stage sync, change accepted when stage 2 and 3 agree
   reg  [11:0] s1, s2, s3, flt;
   wire [11:0] raw = {brownout_i, wake_gpio_i, wake_kbd_i, wake_mouse_i,
                      wake_hub_i, wake_dbg_i, soc_off_wake_input_i,
                      comparator_wake_input_i, supply_ok_i, power_down_pin_i};
   wire power_down_pin   = flt[0];
   wire sup   = flt[1];
   wire w_cmp = flt[2];
   wire w_pin = flt[3];
   wire w_dbg = flt[4];
   wire w_hub = flt[5];
   wire w_ms  = flt[6];
   wire w_kb  = flt[7];
   wire w_gp  = flt[8];
   wire [2:0] brn = flt[11:9];
   integer i;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1  <= 12'h000;
         s2  <= 12'h000;
         s3  <= 12'h000;
         flt <= 12'h001;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         for (i = 0; i < 12; i = i + 1)
            if (s2[i] == s3[i])
               flt[i] <= s2[i];
      end
   end

   // 32 kHz tick from the 50 MHz clock
   reg [10:0] lp_cnt;
   reg        lp_tick;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lp_cnt  <= 11'h000;
         lp_tick <= 1'b0;
      end else if (lp_cnt == `LPS_LP_DIV - 11'd1) begin
         lp_cnt  <= 11'h000;
         lp_tick <= 1'b1;
      end else begin
         lp_cnt  <= lp_cnt + 11'd1;
         lp_tick <= 1'b0;
      end
   end

   reg [2:0]  state;
   reg [2:0]  ctrl_lo;
   reg        idle_en, rsleep;
   reg [7:0]  wake_en, wake_arm, ret_mask, cause;
   reg [39:0] tmr_load, tmr;
   reg [15:0] settle;
   reg [2:0]  brn_sticky;
   wire tmr_hit = (tmr == 40'h0);
   // only sources armed at entry count; later changes have no effect
   wire [7:0] wk = wake_arm & {w_cmp, w_pin, w_dbg, w_hub, w_ms, w_kb,
                               w_gp, tmr_hit};
   wire ret_wake = |wk[5:0];
   wire off_wake = wk[`LPS_W_TMR] | wk[`LPS_W_PIN] | wk[`LPS_W_CMP];
   wire [2:0] cmd = (wr_i && addr_i == `LPS_A_CTRL) ? wdata_i[2:0]
                                                     : `LPS_CMD_NONE;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state      <= ST_RESET;
         ctrl_lo    <= 3'h0;
         idle_en    <= 1'b0;
         rsleep     <= 1'b0;
         wake_en    <= 8'h00;
         wake_arm   <= 8'h00;
         ret_mask   <= `LPS_RET_RST;
         cause      <= 8'h00;
         tmr_load   <= 40'h0;
         tmr        <= 40'h0;
         settle     <= 16'h0000;
         brn_sticky <= 3'h0;
         mod_rst_o  <= 8'h00;
         rdata_o    <= 32'h0;
         io_level_o <= 12'h000;
      end else begin
         mod_rst_o  <= 8'h00;
         brn_sticky <= brn_sticky | brn;
         if (wr_i) begin
            case (addr_i)
               `LPS_A_CTRL: begin
                  idle_en <= wdata_i[`LPS_CTRL_IDLE];
                  rsleep  <= wdata_i[`LPS_CTRL_RSLP];
               end
               `LPS_A_WAKE_EN:  wake_en  <= wdata_i[7:0];
               `LPS_A_RET_MASK: ret_mask <= wdata_i[7:0];
               `LPS_A_TMR_LO:   tmr_load[31:0]  <= wdata_i;
               `LPS_A_TMR_HI:   tmr_load[39:32] <= wdata_i[7:0];
               `LPS_A_SW_RST:   mod_rst_o <= wdata_i[7:0];
               `LPS_A_BROWN:
                  brn_sticky <= (brn_sticky & ~wdata_i[2:0]) | brn;
               default: ;
            endcase
         end
         if (rd_i) begin
            case (addr_i)
               `LPS_A_CTRL:     rdata_o <= {27'h0, rsleep, idle_en, 3'h0};
               `LPS_A_WAKE_EN:  rdata_o <= {24'h0, wake_en};
               `LPS_A_RET_MASK: rdata_o <= {24'h0, ret_mask};
               `LPS_A_TMR_LO:   rdata_o <= tmr_load[31:0];
               `LPS_A_TMR_HI:   rdata_o <= {24'h0, tmr_load[39:32]};
               `LPS_A_STATUS:   rdata_o <= {29'h0, state};
               `LPS_A_CAUSE:    rdata_o <= {24'h0, cause};
               `LPS_A_BROWN:    rdata_o <= {29'h0, brn_sticky};
               default:         rdata_o <= 32'h0;
            endcase
         end else
            rdata_o <= 32'h0;
         if (state == ST_ACT)
            io_level_o <= io_level_i;  // frozen outside active
         // timer also paces a timed wake out of retention
         if (lp_tick && !tmr_hit &&
             (state == ST_RET || state == ST_HIB || state == ST_OFF))
            tmr <= tmr - 40'h1;
         case (state)
            ST_RESET: begin
               // held until supplies settle, then released
               if (power_down_pin || !sup)
                  settle <= 16'h0000;
               else if (settle == `LPS_SETTLE_CYC - 1)
                  state <= ST_ACT;
               else
                  settle <= settle + 16'h0001;
            end
            ST_ACT: begin
               if (cmd != `LPS_CMD_NONE) begin
                  // selections snapshot at the trigger
                  wake_arm <= wake_en;
                  tmr      <= tmr_load;
                  cause    <= 8'h00;
               end
               case (cmd)
                  `LPS_CMD_RET: state <= ST_RET;
                  `LPS_CMD_HIB: state <= ST_HIB;
                  `LPS_CMD_OFF: state <= ST_OFF;
                  default: ;
               endcase
            end
            ST_RET, ST_HIB:
               if (ret_wake) begin
                  cause <= wk;
                  state <= ST_ACT;
               end
            ST_OFF:
               if (off_wake) begin
                  cause  <= wk;
                  settle <= 16'h0000;
                  state  <= ST_RESET;      // cold start
               end
            ST_PWD:
               if (!power_down_pin) begin
                  settle <= 16'h0000;
                  state  <= ST_RESET;
               end
            default: state <= ST_RESET;
         endcase
         // digital domain unpowered: software settings are lost
         if (state == ST_OFF || state == ST_PWD) begin
            idle_en  <= 1'b0;
            rsleep   <= 1'b0;
            wake_en  <= 8'h00;
            ret_mask <= `LPS_RET_RST;
            tmr_load <= 40'h0;
         end
         // pin overrides all; far side holds it 100 us
         if (power_down_pin) begin
            state <= ST_PWD;
            tmr   <= 40'h0;
         end
      end
   end

   // power switches, registered
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chip_rst_n_o   <= 1'b0;
         pwr_core_o     <= 1'b0;
         pwr_top_o      <= 1'b0;
         pwr_radio_o    <= 1'b0;
         pwr_pmu_o      <= 1'b0;
         sram_pwr_o     <= 8'h00;
         cpu_clk_en_o   <= 1'b0;
         io_hold_o      <= 1'b0;
         brownout_irq_o <= 3'h0;
         pstate_o       <= ST_RESET;
      end else begin
         pstate_o       <= state;
         brownout_irq_o <= brn_sticky;
         // retention keeps flip-flop state, so no reset there
         chip_rst_n_o   <= (state == ST_ACT) || (state == ST_RET)
                           || (state == ST_HIB);
         pwr_pmu_o      <= (state != ST_PWD);
         pwr_top_o      <= (state == ST_ACT) || (state == ST_RET)
                           || (state == ST_HIB);
         pwr_core_o     <= (state == ST_ACT) || (state == ST_RET);
         pwr_radio_o    <= (state == ST_ACT) && !rsleep;
         cpu_clk_en_o   <= (state == ST_ACT) &&
                           !(idle_en && cpu_wfi_i);
         io_hold_o      <= (state == ST_RET) || (state == ST_HIB);
         case (state)
            ST_ACT:  sram_pwr_o <= 8'hff;
            ST_RET:  sram_pwr_o <= ret_mask;
            default: sram_pwr_o <= 8'h00;
         endcase
      end
   end
endmodule

//--- testbench/lps_sequencer_props.sv
`timescale 1ns/1ns
`include "lps_consts.vh"
module lps_sequencer_props (
   input wire        clk_i,
   input wire        rst_n_i,
   input wire        power_down_pin_i,
   input wire        supply_ok_i,
   input wire [2:0]  brownout_i,
   input wire        chip_rst_n_o,
   input wire [7:0]  mod_rst_o,
   input wire        pwr_core_o,
   input wire        pwr_top_o,
   input wire        pwr_pmu_o,
   input wire [7:0]  sram_pwr_o,
   input wire        io_hold_o,
   input wire [11:0] io_level_o,
   input wire [2:0]  brownout_irq_o,
   input wire [2:0]  pstate_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_reset_release: assert property (
      $rose(chip_rst_n_o) |-> $past(supply_ok_i)) else $error("early release");
   a_pin_reset: assert property (
      power_down_pin_i [*8] |-> !chip_rst_n_o && !pwr_pmu_o)
      else $error("pin ignored");
   a_rst_pulse: assert property (
      mod_rst_o != 8'h00 |=> mod_rst_o == 8'h00) else $error("pulse long");
   a_active_power: assert property (
      pstate_o == 3'd1 |-> pwr_core_o && pwr_top_o && sram_pwr_o == 8'hff)
      else $error("active domain off");
   a_hold_freeze: assert property (
      io_hold_o && $past(io_hold_o) |-> $stable(io_level_o))
      else $error("held level moved");
   a_hib_memory: assert property (
      pstate_o == 3'd3 |-> sram_pwr_o == 8'h00 && io_hold_o)
      else $error("hib memory on");
   a_off_domains: assert property (
      pstate_o == 3'd4 |-> !pwr_core_o && !pwr_top_o && pwr_pmu_o)
      else $error("off domains wrong");
   a_off_exit: assert property (
      $past(pstate_o) == 3'd4 && pstate_o != 3'd4 && pstate_o != 3'd5
      |-> pstate_o == 3'd0 && !chip_rst_n_o) else $error("warm exit");
   a_brown_flag: assert property (
      brownout_i[0] [*8] |-> brownout_irq_o[0]) else $error("no brownout");
   cover property (pstate_o == 3'd2);
   cover property (pstate_o == 3'd4);
   cover property (pstate_o == 3'd5);
endmodule
bind lps_sequencer lps_sequencer_props i_lps_sequencer_props (
   .clk_i, .rst_n_i, .power_down_pin_i, .supply_ok_i, .brownout_i,
   .chip_rst_n_o, .mod_rst_o, .pwr_core_o, .pwr_top_o, .pwr_pmu_o,
   .sram_pwr_o, .io_hold_o, .io_level_o, .brownout_irq_o, .pstate_o);

//--- testbench/lps_wake_model.sv
`timescale 1ns/1ns
module lps_wake_model (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire [7:0] go_i,
   input  wire       pd_go_i,
   output reg  [7:0] wake_o,
   output wire       supply_ok_o,
   output reg        pd_pin_o
);
   reg [12:0] pcnt;
   reg [5:0]  scnt;
   reg [3:0]  wcnt;
   // supplies settle after reset and after the pin drops
   assign supply_ok_o = (scnt == 6'd50);
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_o <= 8'h00;
         pd_pin_o <= 1'b0;
         {pcnt, scnt, wcnt} <= 23'h0;
      end else begin
         if (pd_pin_o)
            scnt <= 6'h0;
         else if (scnt != 6'd50)
            scnt <= scnt + 6'h1;
         if (pd_go_i) begin // pin held 5000 cycles
            pd_pin_o <= 1'b1;
            pcnt <= 13'd5000;
         end else if (pcnt != 13'h0)
            pcnt <= pcnt - 13'h1;
         else
            pd_pin_o <= 1'b0;
         if (go_i != 8'h00) begin // wake level lasts 8 cycles
            wake_o <= go_i;
            wcnt <= 4'h8;
         end else if (wcnt != 4'h0)
            wcnt <= wcnt - 4'h1;
         else
            wake_o <= 8'h00;
      end
   end
endmodule

//--- testbench/tb_lps_sequencer.sv
`timescale 1ns/1ns
`include "lps_consts.vh"
module tb_lps_sequencer;
   reg         clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, cpu_wfi_i = 0;
   reg         pd_go = 0;
   reg  [3:0]  addr_i = 4'h0;
   reg  [31:0] wdata_i = 32'h0;
   reg  [11:0] io_level_i = 12'h000;
   reg  [2:0]  brownout_i = 3'h0;
   reg  [7:0]  go = 8'h00;
   wire [7:0]  wk, mod_rst_o, sram_pwr_o;
   wire        supply_ok_i, power_down_pin_i, chip_rst_n_o, pwr_core_o;
   wire        pwr_top_o, pwr_radio_o, pwr_pmu_o, cpu_clk_en_o, io_hold_o;
   wire [31:0] rdata_o;
   wire [11:0] io_level_o;
   wire [2:0]  brownout_irq_o, pstate_o;
   integer     err_total = 0, checks_done = 0, i, k, b;
   lps_sequencer i_lps_sequencer (.clk_i, .rst_n_i, .power_down_pin_i,
      .supply_ok_i, .brownout_i, .wake_gpio_i(wk[1]), .wake_kbd_i(wk[2]),
      .wake_mouse_i(wk[3]), .wake_hub_i(wk[4]), .wake_dbg_i(wk[5]),
      .soc_off_wake_input_i(wk[6]), .comparator_wake_input_i(wk[7]),
      .cpu_wfi_i, .io_level_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .chip_rst_n_o, .mod_rst_o, .pwr_core_o, .pwr_top_o, .pwr_radio_o,
      .pwr_pmu_o, .sram_pwr_o, .cpu_clk_en_o, .io_hold_o, .io_level_o,
      .brownout_irq_o, .pstate_o);
   lps_wake_model i_lps_wake_model (.clk_i, .rst_n_i, .go_i(go),
      .pd_go_i(pd_go), .wake_o(wk), .supply_ok_o(supply_ok_i),
      .pd_pin_o(power_down_pin_i));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   task chk(input string nm, input [31:0] s, input [31:0] e);
      checks_done = checks_done + 1;
      if (s !== e) begin
         err_total = err_total + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      @(posedge clk_i); addr_i <= a; wdata_i <= d; wr_i <= 1;
      @(posedge clk_i); wr_i <= 0;
   endtask
   task rd(input [3:0] a, input [31:0] e);
      @(posedge clk_i); addr_i <= a; rd_i <= 1;
      @(posedge clk_i); rd_i <= 0;
      #1 chk("rdata", rdata_o, e);
   endtask
   task wst(input [2:0] s, input integer n);
      for (k = 0; k < n && pstate_o !== s; k = k + 1) begin
         @(posedge clk_i); #1;
      end
      chk("pstate", pstate_o, s);
   endtask
   task pulse(input [7:0] g);
      @(posedge clk_i); go <= g;
      @(posedge clk_i); go <= 8'h00;
   endtask
   task final_report;
      if (err_total == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #1000000 err_total = err_total + 1;
      final_report;
   end
   initial begin
      repeat (6) @(posedge clk_i); rst_n_i <= 1;
      repeat (20) @(posedge clk_i); #1 chk("crst", chip_rst_n_o, 0);
      wst(3'd1, 1000); chk("crst", chip_rst_n_o, 1);
      rd(`LPS_A_RET_MASK, 32'hff);
      rd(4'hf, 32'h0);
      rd(`LPS_A_STATUS, 32'h1);
      wr(`LPS_A_TMR_HI, 32'h1ab); rd(`LPS_A_TMR_HI, 32'hab);
      wr(`LPS_A_SW_RST, 32'ha5); #1 chk("mrst", mod_rst_o, 32'ha5);
      wr(`LPS_A_CTRL, 32'h18); cpu_wfi_i <= 1; repeat (3) @(posedge clk_i);
      #1 chk("radio", {pwr_radio_o, pwr_core_o, cpu_clk_en_o}, 2);
      wr(`LPS_A_CTRL, 32'h0); cpu_wfi_i <= 0; repeat (3) @(posedge clk_i);
      #1 chk("radio", {pwr_radio_o, cpu_clk_en_o}, 3);
      @(posedge clk_i); brownout_i <= 3'h3; repeat (10) @(posedge clk_i);
      // let the brownout filter drop first, as a set beats a clear
      brownout_i <= 3'h0; repeat (6) @(posedge clk_i);
      rd(`LPS_A_BROWN, 32'h3);
      chk("birq", brownout_irq_o, 3);
      wr(`LPS_A_BROWN, 32'h3); rd(`LPS_A_BROWN, 32'h0);
      wr(`LPS_A_RET_MASK, 32'h05);
      for (i = 1; i < 6; i = i + 1) begin
         wr(`LPS_A_WAKE_EN, 32'h1 << i); io_level_i <= 12'h5a5;
         wr(`LPS_A_CTRL, `LPS_CMD_RET); wst(3'd2, 10);
         io_level_i <= 12'h0f0; chk("sram", sram_pwr_o, 5);
         chk("crst", chip_rst_n_o, 1);
         pulse(8'h1 << (i == 5 ? 1 : i + 1)); repeat (12) @(posedge clk_i);
         #1 chk("lvl", {io_hold_o, io_level_o, pstate_o}, 32'had2a);
         pulse(8'h1 << i); wst(3'd1, 20);
         rd(`LPS_A_CAUSE, 32'h1 << i);
      end
      rd(`LPS_A_RET_MASK, 32'h05);
      wr(`LPS_A_WAKE_EN, 32'h0); wr(`LPS_A_CTRL, `LPS_CMD_HIB);
      wst(3'd3, 10); chk("sram", sram_pwr_o, 0);
      @(posedge clk_i); pd_go <= 1; @(posedge clk_i); pd_go <= 0;
      wst(3'd5, 20); chk("pmu", {pwr_pmu_o, chip_rst_n_o}, 0);
      wst(3'd1, 6000); rd(`LPS_A_RET_MASK, 32'hff);
      for (i = 0; i < 3; i = i + 1) begin
         b = (i == 2) ? 0 : i + 6;
         wr(`LPS_A_RET_MASK, 32'h33); wr(`LPS_A_TMR_LO, 32'h2);
         wr(`LPS_A_WAKE_EN, 32'h1 << b); wr(`LPS_A_CTRL, `LPS_CMD_OFF);
         wst(3'd4, 10); chk("pmu", pwr_pmu_o, 1);
         pulse(8'h02); repeat (12) @(posedge clk_i);
         #1 chk("pst", pstate_o, 4);
         if (b != 0) pulse(8'h1 << b);
         wst(3'd0, 4000);
         wst(3'd1, 800); rd(`LPS_A_RET_MASK, 32'hff);
      end
      final_report;
   end
endmodule
